// [core/ldt_timing_ctrl.sv]
// second local bus timing and window size register with data pin control
`timescale 1ns/1ps
module ldt_timing_ctrl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // straps
  input wire logic [1:0] mode,
  input wire logic par_port_mode,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // configuration memory load
  input wire logic cfg_load,
  input wire logic [31:0] cfg_data,
  // local access request
  input wire logic acc_start,
  input wire logic acc_write,
  input wire logic irdy_seen,
  input wire logic acc_end,
  output logic acc_retry,
  // local bus pins
  output logic local_data_oe,
  output logic local_clock_out,
  output logic local_reset,
  output logic bus_style,
  output logic [8:0] bar0_bytes,
  output logic [8:0] bar1_bytes,
  output logic [4:0] ref_count
);
  import ldt_pkg::*;

  // ************************************************************
  // register state
  // ************************************************************
  logic [3:0] wr_on_q, wr_on_d;
  logic [3:0] wr_off_q, wr_off_d;
  logic [3:0] rd_on_q, rd_on_d;
  logic [3:0] rd_off_q, rd_off_d;
  logic [2:0] bar0_q, bar0_d;
  logic [2:0] bar1_q, bar1_d;
  logic swrst_q, swrst_d;
  logic cken_q, cken_d;
  logic style_q, style_d;
  logic mode_rst_q, mode_rst_d;
  logic hit;
  logic [31:0] rdata_q, rdata_d;

  assign hit = (reg_addr == LDT_OFS_TIMING2);

  // register next values
  always_comb begin
    wr_on_d = wr_on_q;
    wr_off_d = wr_off_q;
    rd_on_d = rd_on_q;
    rd_off_d = rd_off_q;
    bar0_d = bar0_q;
    bar1_d = bar1_q;
    swrst_d = swrst_q;
    cken_d = cken_q;
    style_d = style_q;
    rdata_d = rdata_q;
    // mode-dependent defaults take effect once after reset release
    mode_rst_d = 1'b0;
    if (mode_rst_q) begin
      rd_on_d = par_port_mode ? LDT_RST_RD_ON_PP : LDT_RST_RD_ON_LB;
      bar1_d = par_port_mode ? LDT_RST_BAR1_PP : LDT_RST_BAR1_LB;
    end else if (cfg_load) begin
      // memory loads sizes, not the reset bit
      wr_on_d = cfg_data[LDT_WR_ON_LSB +: 4];
      wr_off_d = cfg_data[LDT_WR_OFF_LSB +: 4];
      rd_on_d = cfg_data[LDT_RD_ON_LSB +: 4];
      rd_off_d = cfg_data[LDT_RD_OFF_LSB +: 4];
      bar0_d = cfg_data[LDT_BAR0_LSB +: 3];
      bar1_d = cfg_data[LDT_BAR1_LSB +: 3];
      cken_d = cfg_data[LDT_CKEN_BIT];
      style_d = cfg_data[LDT_STYLE_BIT];
    end else if (reg_wr && hit) begin
      // timing fields writable from the host
      wr_on_d = reg_wdata[LDT_WR_ON_LSB +: 4];
      wr_off_d = reg_wdata[LDT_WR_OFF_LSB +: 4];
      rd_on_d = reg_wdata[LDT_RD_ON_LSB +: 4];
      rd_off_d = reg_wdata[LDT_RD_OFF_LSB +: 4];
      swrst_d = reg_wdata[LDT_SWRST_BIT];
      cken_d = reg_wdata[LDT_CKEN_BIT];
      style_d = reg_wdata[LDT_STYLE_BIT];
    end
    if (mode == LDT_MODE_FORCE_STYLE) begin
      style_d = 1'b0;
    end
    if (reg_rd && hit) begin
      rdata_d = '0;
      rdata_d[LDT_WR_ON_LSB +: 4] = wr_on_q;
      rdata_d[LDT_WR_OFF_LSB +: 4] = wr_off_q;
      rdata_d[LDT_RD_ON_LSB +: 4] = rd_on_q;
      rdata_d[LDT_RD_OFF_LSB +: 4] = rd_off_q;
      rdata_d[LDT_BAR0_LSB +: 3] = bar0_q;
      rdata_d[LDT_BAR1_LSB +: 3] = bar1_q;
      rdata_d[LDT_SWRST_BIT] = swrst_q;
      rdata_d[LDT_CKEN_BIT] = cken_q;
      rdata_d[LDT_STYLE_BIT] = style_q;
    end else if (reg_rd) begin
      rdata_d = 32'h0000_0000;
    end
  end

  // register flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_on_q <= LDT_RST_WR_ON;
      wr_off_q <= LDT_RST_WR_OFF;
      rd_on_q <= LDT_RST_RD_ON_LB;
      rd_off_q <= LDT_RST_RD_OFF;
      bar0_q <= LDT_RST_BAR0;
      bar1_q <= LDT_RST_BAR1_LB;
      swrst_q <= 1'b0;
      cken_q <= 1'b0;
      style_q <= 1'b0;
      mode_rst_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_on_q <= wr_on_d;
      wr_off_q <= wr_off_d;
      rd_on_q <= rd_on_d;
      rd_off_q <= rd_off_d;
      bar0_q <= bar0_d;
      bar1_q <= bar1_d;
      swrst_q <= swrst_d;
      cken_q <= cken_d;
      style_q <= style_d;
      mode_rst_q <= mode_rst_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign bus_style = style_q;
  assign local_reset = swrst_q;

  // ************************************************************
  // local clock output
  // ************************************************************
  logic cken_lo_q;

  // enable retimed on the falling edge: the gate only opens or
  // closes while the clock is low, so no runt pulse leaves the pin
  always_ff @(negedge clk_sys or posedge rst) begin
    if (rst) begin
      cken_lo_q <= 1'b0;
    end else begin
      cken_lo_q <= cken_q;
    end
  end

  // clock is the system clock gated by the retimed enable
  assign local_clock_out = cken_lo_q & clk_sys;

  // ************************************************************
  // window size decode
  // ************************************************************
  ldt_size_dec u_bar0 (
    .code(bar0_q),
    .bytes(bar0_bytes)
  );
  ldt_size_dec u_bar1 (
    .code(bar1_q),
    .bytes(bar1_bytes)
  );

  // ************************************************************
  // access sequencer
  // ************************************************************
  ldt_state_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic [1:0] ref_q, ref_d;
  logic oe_q, oe_d;
  logic wr_q, wr_d;
  logic bad_timing;
  logic hit_wr_on, hit_wr_off, hit_rd_on, hit_rd_off;

  // any field above ten is illegal
  assign bad_timing = (wr_on_q > LDT_MAX_TIMING) ||
    (wr_off_q > LDT_MAX_TIMING) || (rd_on_q > LDT_MAX_TIMING) ||
    (rd_off_q > LDT_MAX_TIMING);
  assign acc_retry = acc_start & bad_timing;

  ldt_field_cmp u_wr_on (
    .count(cnt_q),
    .field(wr_on_q),
    .reached(hit_wr_on)
  );
  ldt_field_cmp u_wr_off (
    .count(cnt_q),
    .field(wr_off_q),
    .reached(hit_wr_off)
  );
  ldt_field_cmp u_rd_on (
    .count(cnt_q),
    .field(rd_on_q),
    .reached(hit_rd_on)
  );
  ldt_field_cmp u_rd_off (
    .count(cnt_q),
    .field(rd_off_q),
    .reached(hit_rd_off)
  );

  // sequencer next state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    ref_d = ref_q;
    oe_d = oe_q;
    wr_d = wr_q;
    unique case (st_q)
      LDT_IDLE: begin
        if (acc_start && !bad_timing && !swrst_q) begin
          wr_d = acc_write;
          ref_d = 2'h0;
          st_d = LDT_WAIT_REF;
        end
      end
      LDT_WAIT_REF: begin
        if (irdy_seen || ref_q != 2'h0) begin
          ref_d = ref_q + 2'h1;
          if (ref_q == LDT_REF_DELAY - 2'h1) begin
            cnt_d = 5'h00;
            st_d = LDT_COUNT;
          end
        end
      end
      LDT_COUNT: begin
        if (cnt_q != LDT_WINDOW_CLKS) begin
          cnt_d = cnt_q + 5'h01;
        end
        if (wr_q) begin
          // drive from write-on, float at write-off
          oe_d = hit_wr_on && !hit_wr_off;
        end else begin
          // float at read-off, redrive at read-on
          oe_d = !hit_rd_off || hit_rd_on;
        end
        if (acc_end) begin
          oe_d = !wr_q;
          st_d = LDT_IDLE;
        end
      end
    endcase
    if (swrst_q) begin
      st_d = LDT_IDLE;
      oe_d = 1'b0;
    end
  end

  // sequencer flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= LDT_IDLE;
      cnt_q <= 5'h00;
      ref_q <= 2'h0;
      oe_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ref_q <= ref_d;
      oe_q <= oe_d;
      wr_q <= wr_d;
    end
  end

  assign local_data_oe = oe_q;
  assign ref_count = cnt_q;
endmodule

// [core/ldt_pkg.sv]
// package: register map, field layout, reset values and timing constants
package ldt_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] LDT_OFS_TIMING2 = 8'h0c;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int LDT_WR_ON_LSB = 0;
  localparam int LDT_WR_OFF_LSB = 4;
  localparam int LDT_RD_ON_LSB = 8;
  localparam int LDT_RD_OFF_LSB = 12;
  localparam int LDT_BAR0_LSB = 20;
  localparam int LDT_BAR1_LSB = 24;
  localparam int LDT_SWRST_BIT = 29;
  localparam int LDT_CKEN_BIT = 30;
  localparam int LDT_STYLE_BIT = 31;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [3:0] LDT_RST_WR_ON = 4'h0;
  localparam logic [3:0] LDT_RST_WR_OFF = 4'hf;
  localparam logic [3:0] LDT_RST_RD_ON_LB = 4'h4;
  localparam logic [3:0] LDT_RST_RD_ON_PP = 4'h2;
  localparam logic [3:0] LDT_RST_RD_OFF = 4'h0;
  localparam logic [2:0] LDT_RST_BAR0 = 3'h2;
  localparam logic [2:0] LDT_RST_BAR1_LB = 3'h2;
  localparam logic [2:0] LDT_RST_BAR1_PP = 3'h1;

  // ************************************************************
  // timing constants
  // ************************************************************
  localparam logic [3:0] LDT_MAX_TIMING = 4'ha;
  localparam logic [1:0] LDT_REF_DELAY = 2'h2;
  localparam logic [1:0] LDT_MODE_FORCE_STYLE = 2'h1;
  localparam logic [4:0] LDT_WINDOW_CLKS = 5'h10;

  // access phase of the local bus sequencer
  typedef enum logic [1:0] {
    LDT_IDLE,
    LDT_WAIT_REF,
    LDT_COUNT
  } ldt_state_t;

endpackage

// [core/ldt_field_cmp.sv]
// comparator: is the access counter at or past a timing field
`timescale 1ns/1ps
module ldt_field_cmp (
  // inputs
  input wire logic [4:0] count,
  input wire logic [3:0] field,
  // result
  output logic reached
);
  // true once counter reaches the programmed count
  assign reached = (count >= {1'b0, field});
endmodule

// [core/ldt_size_dec.sv]
// decoder: three-bit window size code to byte count
`timescale 1ns/1ps
module ldt_size_dec (
  // code
  input wire logic [2:0] code,
  // bytes, zero for the reserved code
  output logic [8:0] bytes
);
  // 001 gives 4 bytes, each step doubles
  always_comb begin
    if (code == 3'h0) begin
      bytes = 9'h000;
    end else begin
      bytes = 9'h002 << code;
    end
  end
endmodule

// [tb/ldt_periph.sv]
// peripheral model: counts local clock edges
`timescale 1ns/1ps
module ldt_periph (
  // local bus side
  input wire logic local_clock_out,
  output int edges
);
  initial edges = 0;
  always @(posedge local_clock_out) begin
    edges <= edges + 1;
  end
endmodule

// [tb/ldt_timing_ctrl_monitor.sv]
// checker: port assertions for the timing register block
`timescale 1ns/1ps
module ldt_timing_ctrl_monitor (
  // clock, reset, straps
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic cfg_load,
  // access
  input wire logic acc_start,
  input wire logic acc_write,
  input wire logic acc_end,
  input wire logic acc_retry,
  // outputs
  input wire logic local_data_oe,
  input wire logic local_clock_out,
  input wire logic local_reset,
  input wire logic bus_style,
  input wire logic [8:0] bar0_bytes,
  input wire logic [8:0] bar1_bytes,
  input wire logic [4:0] ref_count
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_retry_needs_start:
    assert property (acc_retry |-> acc_start) else $error("stray retry");
  a_bar0_legal:
    assert property ($onehot(bar0_bytes) && bar0_bytes >= 9'h004)
    else $error("bad bar0 size");
  a_bar1_legal:
    assert property ($onehot(bar1_bytes) && bar1_bytes >= 9'h004)
    else $error("bad bar1 size");
  a_bar0_fixed:
    assert property (!cfg_load |=> $stable(bar0_bytes))
    else $error("bar0 changed by host");
  a_clk_low_gap:
    assert property (!local_clock_out) else $error("clock out not gated");
  a_style_forced:
    assert property (mode == 2'h1 ##1 mode == 2'h1 |-> !bus_style)
    else $error("style not forced");
  a_swrst_holds_idle:
    assert property (local_reset ##1 local_reset |-> $stable(ref_count))
    else $error("sequencer ran in reset");
  a_write_end_float:
    assert property (acc_end && acc_write |=> !local_data_oe)
    else $error("oe after write end");
  // main scenarios
  cover property (acc_retry);
  cover property ($rose(local_data_oe));
  cover property (local_reset);
endmodule
bind ldt_timing_ctrl ldt_timing_ctrl_monitor ldt_timing_ctrl_monitor_inst (.*);

// [tb/ldt_timing_ctrl_test.sv]
// testbench: register access and data pin timing
`timescale 1ns/1ps
module ldt_timing_ctrl_test;
  import ldt_pkg::*;
  logic clk_sys = 0, rst = 1, par_port_mode = 0, cfg_load = 0;
  logic reg_wr = 0, reg_rd = 0, acc_start = 0, acc_write = 0;
  logic irdy_seen = 0, acc_end = 0, acc_retry, local_data_oe;
  logic local_clock_out, local_reset, bus_style;
  logic [1:0] mode = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, cfg_data = 0, reg_rdata, d;
  logic [8:0] bar0_bytes, bar1_bytes;
  logic [4:0] ref_count;
  int num_errors = 0, checks = 0, n, edges, e0;
  ldt_timing_ctrl ldt_timing_ctrl_inst (.*);
  ldt_periph ldt_periph_inst (.*);
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] v);
    @(negedge clk_sys);
    reg_addr = LDT_OFS_TIMING2;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge clk_sys);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk_sys);
    reg_rd = 0;
    d = reg_rdata;
  endtask
  // starts an access: request, then initiator ready
  task automatic go(input logic w);
    @(negedge clk_sys);
    acc_start = 1;
    acc_write = w;
    @(negedge clk_sys);
    acc_start = 0;
    irdy_seen = 1;
    @(negedge clk_sys);
    irdy_seen = 0;
  endtask
  // waits for counter one past field f, then checks oe
  task automatic at(input logic [3:0] f, input logic e);
    n = 0;
    while (ref_count !== 5'(f) + 5'h1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    cmp32(32'(n < 40), 32'h1);
    cmp32(32'(local_data_oe), 32'(e));
  endtask
  task automatic stop;
    @(negedge clk_sys);
    acc_end = 1;
    @(negedge clk_sys);
    acc_end = 0;
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    test_done;
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    rst = 0;
    repeat (2) @(negedge clk_sys);
    rd(LDT_OFS_TIMING2);
    cmp32(d, 32'h022004f0);
    cmp32(32'(bar0_bytes), 32'h8);
    cmp32(32'(bar1_bytes), 32'h8);
    rd(8'h10);
    cmp32(d, 32'h0);
    wr(32'h40001562);
    e0 = edges;
    repeat (10) @(negedge clk_sys);
    cmp32(32'(edges - e0), 32'ha);
    go(1);
    at(4'h2, 1);
    at(4'h6, 0);
    stop;
    go(0);
    at(4'h1, 0);
    at(4'h5, 1);
    stop;
    cmp32(32'(local_data_oe), 32'h1);
    wr(32'hffffffff);
    rd(LDT_OFS_TIMING2);
    cmp32(d, 32'he220ffff);
    cmp32(32'(local_reset), 32'h1);
    cmp32(32'(local_data_oe), 32'h0);
    @(negedge clk_sys);
    acc_start = 1;
    #1;
    cmp32(32'(acc_retry), 32'h1);
    @(negedge clk_sys);
    acc_start = 0;
    mode = 2'h1;
    repeat (2) @(negedge clk_sys);
    cmp32(32'(bus_style), 32'h0);
    mode = 2'h0;
    wr(32'h0);
    e0 = edges;
    repeat (5) @(negedge clk_sys);
    cmp32(32'(edges - e0), 32'h0);
    cmp32(32'(local_reset), 32'h0);
    cfg_data = 32'h01700000;
    cfg_load = 1;
    @(negedge clk_sys);
    cfg_load = 0;
    @(negedge clk_sys);
    cmp32(32'(bar0_bytes), 32'h100);
    cmp32(32'(bar1_bytes), 32'h4);
    // second reset in mid-run, parallel port mode defaults
    @(negedge clk_sys);
    rst = 1;
    par_port_mode = 1;
    repeat (3) @(negedge clk_sys);
    rst = 0;
    repeat (2) @(negedge clk_sys);
    rd(LDT_OFS_TIMING2);
    cmp32(d, 32'h012002f0);
    cmp32(32'(bar1_bytes), 32'h4);
    cmp32(32'(local_data_oe), 32'h0);
    test_done;
  end
endmodule
